// *** hw/vin_protect_pkg.sv ***
// Constants and carrier types for the input lockout and output overvoltage protection block.
// Assumes the register port of the host processor synchronous to clock_i; comparator levels may be asynchronous to it.
package vin_protect_pkg;

   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;

   // Register indices on the plain register port
   localparam logic [3:0] ADDR_LOCKOUT_CTRL = 4'h0;
   localparam logic [3:0] ADDR_UV_THRESH = 4'h1;
   localparam logic [3:0] ADDR_OV_THRESH = 4'h2;
   localparam logic [3:0] ADDR_OUT_OV_CTRL = 4'h3;
   localparam logic [3:0] ADDR_OUT_OV_REF = 4'h4;
   localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h5;

   // Input lockout control field positions
   localparam int unsigned UV_EN_BIT = 7;
   localparam int unsigned UV_STAT_BIT = 6;
   localparam int unsigned UV_RISE_BIT = 5;
   localparam int unsigned UV_FALL_BIT = 4;
   localparam int unsigned OV_EN_BIT = 3;
   localparam int unsigned OV_STAT_BIT = 2;
   localparam int unsigned OV_RISE_BIT = 1;
   localparam int unsigned OV_FALL_BIT = 0;

   // Output overvoltage control uses the same low nibble layout
   localparam int unsigned OOV_EN_BIT = 3;
   localparam int unsigned OOV_STAT_BIT = 2;
   localparam int unsigned OOV_RISE_BIT = 1;
   localparam int unsigned OOV_FALL_BIT = 0;
   localparam int unsigned OOV_CTRL_W = 4;
   localparam logic [3:0] OOV_CTRL_RESET = 4'h0;

   // Interrupt flag register positions; write one to clear
   localparam int unsigned UV_FLAG_BIT = 0;
   localparam int unsigned IOV_FLAG_BIT = 1;
   localparam int unsigned OOV_FLAG_BIT = 2;

   localparam int unsigned CODE_W = 6;
   localparam int unsigned REF_W = 8;

   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [5:0] CODE_RESET = 6'h00;
   localparam logic [7:0] REF_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // Three comparators: undervoltage, input overvoltage, output overvoltage
   localparam int unsigned CMP_N = 3;
   localparam int unsigned CMP_UV = 0;
   localparam int unsigned CMP_IOV = 1;
   localparam int unsigned CMP_OOV = 2;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic primary_gate_drive;
      logic secondary_gate_drive;
   } gate_s;

endpackage

// *** hw/cmp_edge_flag.sv ***
// One comparator channel: two-flop synchroniser, edge detector and sticky interrupt flag.
// Assumes the comparator level may be asynchronous to clock_i and clear is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module cmp_edge_flag
   import vin_protect_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic cmp_i,
   input wire logic rise_en_i,
   input wire logic fall_en_i,
   input wire logic clear_i,
   output logic level_o,
   output logic flag_o
);

   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
      logic flag;
   } chan_s;

   chan_s state;
   chan_s next_state;
   logic hit;

   always_comb
   begin
      next_state = state;
      next_state.meta = cmp_i;
      next_state.sync = state.meta;
      next_state.prev = state.sync;
      // Compare against last clock's synced value so each transition fires once
      hit = (rise_en_i && state.sync && !state.prev) || (fall_en_i && !state.sync && state.prev);
      // Set beats a same-cycle clear so no edge is lost
      if (hit)
      begin
         next_state.flag = 1'b1;
      end
      else if (clear_i)
      begin
         next_state.flag = 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign level_o = state.sync;
   assign flag_o = state.flag;

endmodule
`default_nettype wire

// *** hw/vin_lockout_and_output_ov_protect.sv ***
// Input under/overvoltage lockout and output overvoltage protection with its registers.
// Assumes analog comparators and DACs live outside; thresholds go out as codes, trip levels come back in.
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module vin_lockout_and_output_ov_protect
   import vin_protect_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic uv_cmp_i,
   input wire logic iov_cmp_i,
   input wire logic oov_cmp_i,
   input wire logic pwm_primary_i,
   input wire logic pwm_secondary_i,
   output logic [5:0] undervoltage_code_o,
   output logic [5:0] input_overvoltage_code_o,
   output logic [7:0] output_overvoltage_reference_o,
   output logic primary_gate_drive_o,
   output logic secondary_gate_drive_o,
   output logic undervoltage_irq_flag_o,
   output logic input_overvoltage_irq_flag_o,
   output logic output_overvoltage_irq_flag_o
);

   typedef struct packed {
      logic [7:0] lockout_ctrl;
      logic [5:0] uv_code;
      logic [5:0] ov_code;
      logic [OOV_CTRL_W-1:0] oov_ctrl;
      logic [7:0] oov_ref;
      logic [7:0] rdata;
      gate_s gate;
   } top_s;

   top_s state;
   top_s next_state;
   reg_req_s req;
   logic [CMP_N-1:0] cmp_raw;
   logic [CMP_N-1:0] cmp_level;
   logic [CMP_N-1:0] cmp_flag;
   logic [CMP_N-1:0] rise_en;
   logic [CMP_N-1:0] fall_en;
   logic [CMP_N-1:0] flag_clear;
   logic [7:0] ctrl_view;
   logic [7:0] oov_view;
   logic uv_trip;
   logic iov_trip;
   logic oov_trip;

   assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

   // Comparator senses: UV high when below level output OV high when sense exceeds DAC
   assign cmp_raw[CMP_UV] = uv_cmp_i;
   assign cmp_raw[CMP_IOV] = iov_cmp_i;
   assign cmp_raw[CMP_OOV] = oov_cmp_i;

   // Edge selects are independent of the enable bits and of any global gate
   assign rise_en[CMP_UV] = state.lockout_ctrl[UV_RISE_BIT];
   assign fall_en[CMP_UV] = state.lockout_ctrl[UV_FALL_BIT];
   assign rise_en[CMP_IOV] = state.lockout_ctrl[OV_RISE_BIT];
   assign fall_en[CMP_IOV] = state.lockout_ctrl[OV_FALL_BIT];
   assign rise_en[CMP_OOV] = state.oov_ctrl[OOV_RISE_BIT];
   assign fall_en[CMP_OOV] = state.oov_ctrl[OOV_FALL_BIT];

   // Only the flag register clears flags, by writing ones
   assign flag_clear[CMP_UV] = req.wr && (req.addr == ADDR_IRQ_FLAGS) && req.wdata[UV_FLAG_BIT];
   assign flag_clear[CMP_IOV] = req.wr && (req.addr == ADDR_IRQ_FLAGS) && req.wdata[IOV_FLAG_BIT];
   assign flag_clear[CMP_OOV] = req.wr && (req.addr == ADDR_IRQ_FLAGS) && req.wdata[OOV_FLAG_BIT];

   genvar g;
   generate
      for (g = 0; g < CMP_N; g++)
      begin : g_chan
         cmp_edge_flag u_chan (
            .clock_i(clock_i),
            .rst_b_i(rst_b_i),
            .cmp_i(cmp_raw[g]),
            .rise_en_i(rise_en[g]),
            .fall_en_i(fall_en[g]),
            .clear_i(flag_clear[g]),
            .level_o(cmp_level[g]),
            .flag_o(cmp_flag[g])
         );
      end
   endgenerate

   // Status bits follow the live comparator, so they clear on recovery
   always_comb
   begin
      ctrl_view = state.lockout_ctrl;
      ctrl_view[UV_STAT_BIT] = cmp_level[CMP_UV];
      ctrl_view[OV_STAT_BIT] = cmp_level[CMP_IOV];
      oov_view = READ_ZERO;
      oov_view[OOV_CTRL_W-1:0] = state.oov_ctrl;
      oov_view[OOV_STAT_BIT] = cmp_level[CMP_OOV];
   end

   assign uv_trip = state.lockout_ctrl[UV_EN_BIT] && cmp_level[CMP_UV];
   assign iov_trip = state.lockout_ctrl[OV_EN_BIT] && cmp_level[CMP_IOV];
   assign oov_trip = state.oov_ctrl[OOV_EN_BIT] && cmp_level[CMP_OOV];

   always_comb
   begin
      next_state = state;
      if (req.wr)
      begin
         unique case (req.addr)
            ADDR_LOCKOUT_CTRL:
            begin
               // Status positions are read-only; the stored copies stay zero
               next_state.lockout_ctrl = req.wdata;
               next_state.lockout_ctrl[UV_STAT_BIT] = 1'b0;
               next_state.lockout_ctrl[OV_STAT_BIT] = 1'b0;
            end
            ADDR_UV_THRESH:
            begin
               next_state.uv_code = req.wdata[CODE_W-1:0];
            end
            ADDR_OV_THRESH:
            begin
               next_state.ov_code = req.wdata[CODE_W-1:0];
            end
            ADDR_OUT_OV_CTRL:
            begin
               next_state.oov_ctrl = req.wdata[OOV_CTRL_W-1:0];
               next_state.oov_ctrl[OOV_STAT_BIT] = 1'b0;
            end
            ADDR_OUT_OV_REF:
            begin
               next_state.oov_ref = req.wdata;
            end
            default:
            begin
               next_state.oov_ref = state.oov_ref;
            end
         endcase
      end
      next_state.rdata = READ_ZERO;
      if (req.rd)
      begin
         unique case (req.addr)
            ADDR_LOCKOUT_CTRL:
            begin
               next_state.rdata = ctrl_view;
            end
            ADDR_UV_THRESH:
            begin
               next_state.rdata = {{(DATA_W-CODE_W){1'b0}}, state.uv_code};
            end
            ADDR_OV_THRESH:
            begin
               next_state.rdata = {{(DATA_W-CODE_W){1'b0}}, state.ov_code};
            end
            ADDR_OUT_OV_CTRL:
            begin
               next_state.rdata = oov_view;
            end
            ADDR_OUT_OV_REF:
            begin
               next_state.rdata = state.oov_ref;
            end
            ADDR_IRQ_FLAGS:
            begin
               next_state.rdata = {{(DATA_W-CMP_N){1'b0}}, cmp_flag};
            end
            default:
            begin
               next_state.rdata = READ_ZERO;
            end
         endcase
      end
      // Output overvoltage wins: secondary held on to clamp the output
      if (oov_trip)
      begin
         next_state.gate.primary_gate_drive = 1'b0;
         next_state.gate.secondary_gate_drive = 1'b1;
      end
      else if (uv_trip || iov_trip)
      begin
         next_state.gate.primary_gate_drive = 1'b0;
         next_state.gate.secondary_gate_drive = 1'b0;
      end
      else
      begin
         next_state.gate.primary_gate_drive = pwm_primary_i;
         next_state.gate.secondary_gate_drive = pwm_secondary_i;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state.lockout_ctrl <= CTRL_RESET;
         state.uv_code <= CODE_RESET;
         state.ov_code <= CODE_RESET;
         state.oov_ctrl <= OOV_CTRL_RESET;
         state.oov_ref <= REF_RESET;
         state.rdata <= READ_ZERO;
         state.gate <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign reg_rdata_o = state.rdata;
   assign undervoltage_code_o = state.uv_code;
   assign input_overvoltage_code_o = state.ov_code;
   assign output_overvoltage_reference_o = state.oov_ref;
   assign primary_gate_drive_o = state.gate.primary_gate_drive;
   assign secondary_gate_drive_o = state.gate.secondary_gate_drive;
   assign undervoltage_irq_flag_o = cmp_flag[CMP_UV];
   assign input_overvoltage_irq_flag_o = cmp_flag[CMP_IOV];
   assign output_overvoltage_irq_flag_o = cmp_flag[CMP_OOV];

endmodule
`default_nettype wire

// *** sim/vin_protect_sva.sv ***
// Checker for the protection block: edge flags, flag hold, gate forcing, read port.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module vin_protect_sva
   import vin_protect_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic uv_cmp_i,
   input wire logic iov_cmp_i,
   input wire logic oov_cmp_i,
   input wire logic pwm_primary_i,
   input wire logic pwm_secondary_i,
   input wire logic primary_gate_drive_o,
   input wire logic secondary_gate_drive_o,
   input wire logic undervoltage_irq_flag_o,
   input wire logic input_overvoltage_irq_flag_o,
   input wire logic output_overvoltage_irq_flag_o
);
   // Control bits rebuilt from the write port, so no internal probe is needed
   logic [7:0] ctl;
   logic [3:0] octl;
   // A flag-register write inside an edge window may legally clear the flag before it is checked
   logic clr_wr;
   assign clr_wr = reg_wr_i && (reg_addr_i == ADDR_IRQ_FLAGS);
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ctl <= 8'h00;
         octl <= 4'h0;
      end
      else if (reg_wr_i)
      begin
         if (reg_addr_i == ADDR_LOCKOUT_CTRL)
            ctl <= reg_wdata_i;
         if (reg_addr_i == ADDR_OUT_OV_CTRL)
            octl <= reg_wdata_i[3:0];
      end
   end
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (!rst_b_i);
   sequence uv_up_s;
      $rose(uv_cmp_i) ##1 (uv_cmp_i && ctl[5] && !clr_wr)[*3];
   endsequence
   sequence uv_dn_s;
      $fell(uv_cmp_i) ##1 (!uv_cmp_i && ctl[4] && !clr_wr)[*3];
   endsequence
   sequence iov_up_s;
      $rose(iov_cmp_i) ##1 (iov_cmp_i && ctl[1] && !clr_wr)[*3];
   endsequence
   sequence oov_dn_s;
      $fell(oov_cmp_i) ##1 (!oov_cmp_i && octl[0] && !clr_wr)[*3];
   endsequence
   uv_rise_flag_a: assert property (uv_up_s |=> undervoltage_irq_flag_o)
      else $error("uv rise not flagged");
   uv_fall_flag_a: assert property (uv_dn_s |=> undervoltage_irq_flag_o)
      else $error("uv fall not flagged");
   iov_rise_flag_a: assert property (iov_up_s |=> input_overvoltage_irq_flag_o)
      else $error("iov rise not flagged");
   oov_fall_flag_a: assert property (oov_dn_s |=> output_overvoltage_irq_flag_o)
      else $error("oov fall not flagged");
   uv_flag_hold_a: assert property (undervoltage_irq_flag_o && !(reg_wr_i && reg_addr_i == ADDR_IRQ_FLAGS)
      |=> undervoltage_irq_flag_o) else $error("uv flag dropped");
   uv_lock_gate_a: assert property ((uv_cmp_i && ctl[7] && !oov_cmp_i)[*4]
      |=> !primary_gate_drive_o && !secondary_gate_drive_o) else $error("uv lockout gates on");
   oov_force_gate_a: assert property ((oov_cmp_i && octl[3])[*4]
      |=> !primary_gate_drive_o && secondary_gate_drive_o) else $error("oov gates wrong");
   gate_follow_a: assert property ((!uv_cmp_i && !iov_cmp_i && !oov_cmp_i)[*4]
      |=> primary_gate_drive_o == $past(pwm_primary_i) && secondary_gate_drive_o == $past(pwm_secondary_i))
      else $error("gates not following pwm");
   rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == READ_ZERO)
      else $error("read data outside slot");
endmodule
bind vin_lockout_and_output_ov_protect vin_protect_sva sva (.*);
`default_nettype wire

// *** sim/vin_lockout_and_output_ov_protect_bench.sv ***
// Self-checking bench: register port, edge flags, status bits and gate forcing.
// Assumes reads answer one cycle late and comparators pass two sync flops.
`timescale 1ns/1ps
`default_nettype none
module vin_lockout_and_output_ov_protect_bench
   import vin_protect_pkg::*;
;
   logic clock_i, rst_b_i, reg_wr_i, reg_rd_i, uv_cmp_i, iov_cmp_i, oov_cmp_i;
   logic pwm_primary_i, pwm_secondary_i, primary_gate_drive_o, secondary_gate_drive_o;
   logic undervoltage_irq_flag_o, input_overvoltage_irq_flag_o, output_overvoltage_irq_flag_o;
   logic [3:0] reg_addr_i;
   logic [7:0] reg_wdata_i, reg_rdata_o, output_overvoltage_reference_o;
   logic [5:0] undervoltage_code_o, input_overvoltage_code_o;
   int failures, checks;
   // Flags in bits 4..2, primary gate bit 1, secondary gate bit 0
   wire logic [7:0] pv = {3'h0, undervoltage_irq_flag_o, input_overvoltage_irq_flag_o,
      output_overvoltage_irq_flag_o, primary_gate_drive_o, secondary_gate_drive_o};
   vin_lockout_and_output_ov_protect dut (.*);
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // A gap cycle after each strobe keeps a strobe from being assigned twice in one step
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 cmp(reg_rdata_o, e);
      @(posedge clock_i);
   endtask
   task automatic pin(input logic [7:0] e);
      #1 cmp(pv, e);
      @(posedge clock_i);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task automatic close_out();
      if (failures == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   initial
   begin
      repeat (3000) @(posedge clock_i);
      failures++;
      close_out();
   end
   initial
   begin
      failures = 0;
      checks = 0;
      rst_b_i = 1'b0;
      reg_addr_i = 4'h0;
      reg_wdata_i = 8'h00;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      uv_cmp_i = 1'b0;
      iov_cmp_i = 1'b0;
      oov_cmp_i = 1'b0;
      pwm_primary_i = 1'b1;
      pwm_secondary_i = 1'b1;
      idle(5);
      rst_b_i <= 1'b1;
      rd(ADDR_LOCKOUT_CTRL, 8'h00);
      rd(ADDR_OUT_OV_CTRL, 8'h00);
      pin(8'h03);
      wr(ADDR_UV_THRESH, 8'hFF);
      rd(ADDR_UV_THRESH, 8'h3F);
      wr(ADDR_OV_THRESH, 8'hC5);
      rd(ADDR_OV_THRESH, 8'h05);
      wr(ADDR_OUT_OV_REF, 8'hA5);
      rd(ADDR_OUT_OV_REF, 8'hA5);
      wr(4'h7, 8'hFF);
      rd(4'h7, 8'h00);
      #1 cmp(output_overvoltage_reference_o, 8'hA5);
      cmp({2'h0, input_overvoltage_code_o}, 8'h05);
      cmp({2'h0, undervoltage_code_o}, 8'h3F);
      @(posedge clock_i);
      wr(ADDR_LOCKOUT_CTRL, 8'h20);
      uv_cmp_i <= 1'b1;
      idle(4);
      pin(8'h13);
      wr(ADDR_LOCKOUT_CTRL, 8'h64);
      rd(ADDR_LOCKOUT_CTRL, 8'h60);
      pin(8'h13);
      wr(ADDR_LOCKOUT_CTRL, 8'hA0);
      idle(1);
      pin(8'h10);
      wr(ADDR_IRQ_FLAGS, 8'h01);
      pin(8'h00);
      uv_cmp_i <= 1'b0;
      idle(4);
      pin(8'h03);
      rd(ADDR_LOCKOUT_CTRL, 8'hA0);
      wr(ADDR_LOCKOUT_CTRL, 8'h10);
      uv_cmp_i <= 1'b1;
      idle(4);
      pin(8'h03);
      uv_cmp_i <= 1'b0;
      idle(4);
      pin(8'h13);
      wr(ADDR_IRQ_FLAGS, 8'hFF);
      wr(ADDR_LOCKOUT_CTRL, 8'h0B);
      iov_cmp_i <= 1'b1;
      idle(4);
      pin(8'h08);
      rd(ADDR_LOCKOUT_CTRL, 8'h0F);
      rd(ADDR_IRQ_FLAGS, 8'h02);
      wr(ADDR_IRQ_FLAGS, 8'h02);
      iov_cmp_i <= 1'b0;
      idle(4);
      pin(8'h0B);
      wr(ADDR_IRQ_FLAGS, 8'h02);
      wr(ADDR_OUT_OV_CTRL, 8'hFB);
      rd(ADDR_OUT_OV_CTRL, 8'h0B);
      oov_cmp_i <= 1'b1;
      idle(4);
      pin(8'h05);
      rd(ADDR_OUT_OV_CTRL, 8'h0F);
      wr(ADDR_IRQ_FLAGS, 8'h04);
      oov_cmp_i <= 1'b0;
      idle(4);
      pin(8'h07);
      rst_b_i <= 1'b0;
      idle(2);
      pin(8'h00);
      rst_b_i <= 1'b1;
      rd(ADDR_LOCKOUT_CTRL, 8'h00);
      rd(ADDR_IRQ_FLAGS, 8'h00);
      pin(8'h03);
      close_out();
   end
endmodule
`default_nettype wire
